// file: core/capg_pkg.sv
// Purpose: constants for the code acquisition and spreading code generator
// Assumes: pclk stands in for the tracking oscillator, 10 MHz, 100 ns period
// Notes:   register map, field positions, reset values and timing counts

// ==========================================================================
// Package
package capg_pkg;

   // ========================================================================
   // Register bus
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_DWELL = 12'h004;
   localparam logic [11:0] ADDR_THR_QUAD = 12'h008;
   localparam logic [11:0] ADDR_THR_BI = 12'h00c;
   localparam logic [11:0] ADDR_STATUS = 12'h010;
   localparam logic [11:0] ADDR_POS = 12'h014;

   // Control fields
   localparam int CTRL_RUN = 0;
   localparam int CTRL_BIPHASE = 1;
   localparam int CTRL_EXT = 2;
   localparam int CTRL_RESTART = 3;

   // Status fields
   localparam int STAT_LOCK = 0;
   localparam int STAT_PASS = 1;
   localparam int STAT_STUCK = 2;
   localparam int STAT_SEARCH = 3;

   // Reset values
   localparam logic [7:0] THR_QUAD_RESET = 8'h80;
   localparam logic [7:0] THR_BI_RESET = 8'h80;

   // ========================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int DIV_RATIO = 4;
   localparam logic [1:0] CODE_DIV_LAST = 2'h3;
   localparam logic [1:0] CODE_DIV_SLIP = 2'h2;
   localparam int DWELL_NS = 361000;
   localparam int DWELL_TICKS_DEF = DWELL_NS / (CLK_PERIOD_NS * DIV_RATIO);
   localparam int DUMP_NS = 11000;
   localparam int DUMP_CYC = (DUMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_NS = 1000;
   localparam int SYNC_CYC = (SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ========================================================================
   // Code generator
   localparam int LFSR_LEN = 11;
   localparam logic [12:0] QPOS_COUNT = 13'h1ffc;
   localparam logic [3:0] RUN_LIMIT = 4'hb;
   localparam logic [8:0] SEED_LOW = 9'h1ff;
   localparam logic [10:0] SYNC_STATE_DEF = 11'h7ff;

   // Acquisition states, one-hot
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_SEARCH = 3'b010,
      ST_LOCKED = 3'b100
   } capg_state_type;

endpackage : capg_pkg

// file: core/capg_top.sv
// Purpose: acquisition controller and 11-stage spreading code generator
// Assumes: APB slave, zero wait; comparator and external code synchronous
// Notes:   pclk is the oscillator; code and acquisition clocks are ticks of it
//
// Chosen here: the APB slave port and the register offsets.

`timescale 1ns/10ps

module capg_top
#(
   parameter logic [10:0] SYNC_STATE = capg_pkg::SYNC_STATE_DEF,
   parameter int DWELL_TICKS = capg_pkg::DWELL_TICKS_DEF
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [capg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Correlation channel
   input wire logic comp_in,
   output logic dump_out,
   output logic step_out,
   output logic lock_out,
   output logic track_en,
   output logic [7:0] thresh_code,
   output logic thresh_biphase,
   output logic search_pass,
   // Spreading code
   input wire logic ext_en_in,
   input wire logic ext_code_in,
   output logic code_true,
   output logic code_comp,
   output logic code_early,
   output logic chip_clk,
   output logic sync_out
);
   import capg_pkg::*;

   // =======================================================================
   // Register bus
   logic ctrl_run, ctrl_bi, ctrl_ext, stuck_seen, restart;
   logic next_ctrl_run, next_ctrl_bi, next_ctrl_ext, next_restart;
   logic [11:0] dwell_len, next_dwell_len;
   logic [7:0] thr_quad, thr_bi, next_thr_quad, next_thr_bi;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic wr_access, setup, addr_ok, stuck_clr;
   capg_state_type state, next_state;
   logic pass;
   logic [12:0] pos;

   assign pready = 1'b1;
   assign wr_access = psel && penable && pwrite;
   assign setup = psel && !penable;
   assign addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_DWELL) || (paddr == ADDR_THR_QUAD)
      || (paddr == ADDR_THR_BI) || (paddr == ADDR_STATUS) || (paddr == ADDR_POS);
   assign stuck_clr = wr_access && (paddr == ADDR_STATUS) && pwdata[STAT_STUCK];

   // Writes land in the access phase; read data is latched in setup
   always_comb
   begin
      next_ctrl_run = ctrl_run;
      next_ctrl_bi = ctrl_bi;
      next_ctrl_ext = ctrl_ext;
      next_dwell_len = dwell_len;
      next_thr_quad = thr_quad;
      next_thr_bi = thr_bi;
      next_restart = 1'b0;
      next_prdata = prdata;
      next_pslverr = pslverr;
      if (wr_access)
      begin
         case (paddr)
            ADDR_CTRL:
            begin
               next_ctrl_run = pwdata[CTRL_RUN];
               next_ctrl_bi = pwdata[CTRL_BIPHASE];
               next_ctrl_ext = pwdata[CTRL_EXT];
               next_restart = pwdata[CTRL_RESTART];
            end
            ADDR_DWELL: next_dwell_len = pwdata[11:0];
            ADDR_THR_QUAD: next_thr_quad = pwdata[7:0];
            ADDR_THR_BI: next_thr_bi = pwdata[7:0];
            default: next_restart = 1'b0;
         endcase
      end
      if (setup)
      begin
         next_pslverr = !addr_ok;
         case (paddr)
            ADDR_CTRL: next_prdata = {29'h0, ctrl_ext, ctrl_bi, ctrl_run};
            ADDR_DWELL: next_prdata = {20'h0, dwell_len};
            ADDR_THR_QUAD: next_prdata = {24'h0, thr_quad};
            ADDR_THR_BI: next_prdata = {24'h0, thr_bi};
            ADDR_STATUS: next_prdata = {28'h0, state == ST_SEARCH, stuck_seen, pass, state == ST_LOCKED};
            ADDR_POS: next_prdata = {19'h0, pos};
            default: next_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_run <= 1'b0;
         ctrl_bi <= 1'b0;
         ctrl_ext <= 1'b0;
         restart <= 1'b0;
         dwell_len <= 12'(DWELL_TICKS);
         thr_quad <= THR_QUAD_RESET;
         thr_bi <= THR_BI_RESET;
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         ctrl_run <= next_ctrl_run;
         ctrl_bi <= next_ctrl_bi;
         ctrl_ext <= next_ctrl_ext;
         restart <= next_restart;
         dwell_len <= next_dwell_len;
         thr_quad <= next_thr_quad;
         thr_bi <= next_thr_bi;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // =======================================================================
   // Dividers and code generator
   logic [1:0] code_div, next_code_div, acq_div, next_acq_div;
   logic [8:0] lfsr, next_lfsr;
   logic t10, t11, next_t10, next_t11;
   logic [3:0] run_cnt, next_run_cnt;
   logic [3:0] sync_cnt, next_sync_cnt;
   logic step_pend, next_step_pend, next_stuck_seen;
   logic next_code_comp, next_chip_clk, next_sync_out;
   logic code_tick, acq_tick, slip_done, stuck_hit, sync_hit, ext_active, fb;
   logic dwell_miss;

   assign ext_active = ctrl_ext || ext_en_in;
   assign acq_tick = (acq_div == CODE_DIV_LAST);
   assign slip_done = step_pend && (code_div == CODE_DIV_SLIP);
   assign code_tick = (code_div == CODE_DIV_LAST) || slip_done;
   assign fb = lfsr[8] ^ t11;
   // Twelve equal chips cannot occur in a valid word
   assign stuck_hit = code_tick && !ext_active && (t10 == t11) && (run_cnt == RUN_LIMIT - 4'h1);
   assign sync_hit = code_tick && ({lfsr, t10, t11} == SYNC_STATE);

   always_comb
   begin
      next_acq_div = acq_div + 2'h1;
      next_code_div = code_tick ? 2'h0 : code_div + 2'h1;
      // A new step request wins over the slip that retires the old one
      next_step_pend = dwell_miss || (step_pend && !slip_done);
      next_lfsr = lfsr;
      next_t10 = t10;
      next_t11 = t11;
      next_run_cnt = run_cnt;
      if (stuck_hit)
      begin
         next_lfsr = SEED_LOW;
         next_t10 = 1'b1;
         next_t11 = 1'b1;
         next_run_cnt = 4'h0;
      end
      else if (code_tick)
      begin
         next_lfsr = {lfsr[7:0], fb};
         next_t10 = ext_active ? ext_code_in : lfsr[8];
         next_t11 = t10;
         next_run_cnt = (t10 == t11) ? run_cnt + 4'h1 : 4'h0;
      end
      next_stuck_seen = stuck_hit || (stuck_seen && !stuck_clr);
      next_sync_cnt = sync_hit ? 4'(SYNC_CYC) : ((sync_cnt != 4'h0) ? sync_cnt - 4'h1 : 4'h0);
      next_sync_out = (next_sync_cnt != 4'h0);
      next_code_comp = !next_t11;
      // Chip clock for an outside code source
      next_chip_clk = (next_code_div < 2'h2);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         code_div <= 2'h0;
         acq_div <= 2'h0;
         step_pend <= 1'b0;
         lfsr <= SEED_LOW;
         t10 <= 1'b1;
         t11 <= 1'b1;
         run_cnt <= 4'h0;
         stuck_seen <= 1'b0;
         sync_cnt <= 4'h0;
         sync_out <= 1'b0;
         code_comp <= 1'b0;
         chip_clk <= 1'b1;
      end
      else
      begin
         code_div <= next_code_div;
         acq_div <= next_acq_div;
         step_pend <= next_step_pend;
         lfsr <= next_lfsr;
         t10 <= next_t10;
         t11 <= next_t11;
         run_cnt <= next_run_cnt;
         stuck_seen <= next_stuck_seen;
         sync_cnt <= next_sync_cnt;
         sync_out <= next_sync_out;
         code_comp <= next_code_comp;
         chip_clk <= next_chip_clk;
      end
   end

   assign code_true = t11;
   assign code_early = t10;

   // =======================================================================
   // Acquisition sequencer
   logic [11:0] dwell_cnt, next_dwell_cnt;
   logic [12:0] next_pos;
   logic [7:0] dump_cnt, next_dump_cnt;
   logic next_pass, next_dump_out, next_step_out, next_lock, next_bi;
   logic [7:0] next_thresh;
   logic dwell_end;

   // Dwell counts acquisition ticks only, never steps
   assign dwell_end = acq_tick && (state != ST_IDLE) && (dwell_cnt == dwell_len - 12'h1);
   assign dwell_miss = dwell_end && (state == ST_SEARCH) && !comp_in;

   always_comb
   begin
      next_state = state;
      next_dwell_cnt = dwell_cnt;
      next_pos = pos;
      next_pass = pass;
      case (state)
         ST_IDLE: if (ctrl_run && !restart) next_state = ST_SEARCH;
         ST_SEARCH: if (dwell_end && comp_in) next_state = ST_LOCKED;
         ST_LOCKED: next_state = ST_LOCKED;
         default: next_state = ST_IDLE;
      endcase
      if (acq_tick && state != ST_IDLE)
         next_dwell_cnt = dwell_end ? 12'h0 : dwell_cnt + 12'h1;
      if (dwell_miss)
      begin
         // Wrapping the word ends one pass; quadriphase searches twice
         next_pos = (pos == QPOS_COUNT - 13'h1) ? 13'h0 : pos + 13'h1;
         if (pos == QPOS_COUNT - 13'h1 && !ctrl_bi)
            next_pass = !pass;
      end
      if (!ctrl_run || restart)
      begin
         next_state = ST_IDLE;
         next_dwell_cnt = 12'h0;
         next_pos = 13'h0;
         next_pass = 1'b0;
      end
      next_dump_cnt = dwell_end ? 8'(DUMP_CYC) : ((dump_cnt != 8'h0) ? dump_cnt - 8'h1 : 8'h0);
      next_dump_out = (next_dump_cnt != 8'h0);
      next_step_out = dwell_miss;
      next_lock = (next_state == ST_LOCKED);
      next_bi = ctrl_bi;
      next_thresh = ctrl_bi ? thr_bi : thr_quad;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= ST_IDLE;
         dwell_cnt <= 12'h0;
         pos <= 13'h0;
         pass <= 1'b0;
         dump_cnt <= 8'h0;
         dump_out <= 1'b0;
         step_out <= 1'b0;
         lock_out <= 1'b0;
         track_en <= 1'b0;
         thresh_biphase <= 1'b0;
         thresh_code <= THR_QUAD_RESET;
      end
      else
      begin
         state <= next_state;
         dwell_cnt <= next_dwell_cnt;
         pos <= next_pos;
         pass <= next_pass;
         dump_cnt <= next_dump_cnt;
         dump_out <= next_dump_out;
         step_out <= next_step_out;
         lock_out <= next_lock;
         track_en <= next_lock;
         thresh_biphase <= next_bi;
         thresh_code <= next_thresh;
      end
   end

   assign search_pass = pass;

   // =======================================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   AST_DUMP_AFTER_DWELL: assert property (dwell_end |=> dump_out [*8])
      else $error("dump pulse missing after dwell end");
   AST_STEP_ON_MISS: assert property (dwell_end && state == ST_SEARCH && !comp_in |=> step_pend && step_out)
      else $error("no step after a miss");
   AST_LOCK_ON_HIT: assert property (dwell_end && state == ST_SEARCH && comp_in && ctrl_run && !restart
      |=> lock_out && !step_out && !step_pend)
      else $error("no lock after a hit");
   AST_TRACK_AT_HIT: assert property ($rose(track_en) |-> $past(dwell_end) && $past(comp_in))
      else $error("tracking connected without a hit");
   // Same cycle: the path registers from the same next state as the sequencer
   AST_TRACK_OFF_UNLOCKED: assert property (state != ST_LOCKED |-> !track_en)
      else $error("tracking path on while unlocked");
   AST_SLIP_DIV3: assert property ($fell(step_pend) |-> $past(code_div) == CODE_DIV_SLIP && code_div == 2'h0)
      else $error("step slip not a divide by three");
   AST_ACQ_STEADY: assert property (acq_tick |=> !acq_tick [*3] ##1 acq_tick)
      else $error("acquisition tick not every fourth cycle");
   AST_FEEDBACK: assert property (code_tick && !stuck_hit |=> lfsr[0] == $past(fb))
      else $error("feedback not from stages 9 and 11");
   AST_COMPLEMENT: assert property (code_comp != code_true)
      else $error("code outputs not complementary");
   AST_STUCK_RELOAD: assert property (stuck_hit |=> lfsr == SEED_LOW && t11 && stuck_seen)
      else $error("stuck register not reloaded");
   AST_SYNC_STRETCH: assert property ($rose(sync_out) |-> sync_out [*8])
      else $error("sync pulse too short");
   AST_EXT_INJECT: assert property (code_tick && ext_active && !stuck_hit |=> t10 == $past(ext_code_in))
      else $error("external code not injected");
   AST_THR_MODE: assert property (1'b1 |=> thresh_code == ($past(ctrl_bi) ? $past(thr_bi) : $past(thr_quad)))
      else $error("threshold not the mode setting");
   AST_POS_STEP: assert property (dwell_miss && ctrl_run && !restart && pos < QPOS_COUNT - 13'h1
      |=> pos == $past(pos) + 13'h1)
      else $error("position counter did not follow step");

   COV_STEP: cover property (step_out);
   COV_LOCK: cover property ($rose(lock_out));
   COV_STUCK: cover property (stuck_hit);
   COV_SYNC: cover property ($rose(sync_out));

endmodule : capg_top

// file: tb/capg_partner.sv
// Purpose: far-side model, comparator and external code source
// Assumes: alignment is reached after align_steps quarter-chip steps
// Notes:   off alignment the comparator chatters only while the integrator dumps
`timescale 1ns/10ps

// ==========================================================================
// Partner model
module capg_partner
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // From the block, and align_steps from the bench
   input wire logic step_out,
   input wire logic dump_out,
   input wire logic chip_clk,
   input wire logic [3:0] align_steps,
   // To the block
   output logic comp_in,
   output logic ext_code_in
);
   logic [3:0] steps;
   logic [4:0] ext_sr;
   logic chip_q;
   logic noise;

   // Step count stands in for code phase; chatter off the dwell end must not steer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         steps <= 4'h0;
         noise <= 1'b0;
         comp_in <= 1'b0;
      end
      else
      begin
         steps <= steps + {3'h0, step_out};
         noise <= ~noise;
         comp_in <= (steps >= align_steps) | (dump_out & noise);
      end
   end

   // External code moves one pclk cycle after the chip clock fall, three quarters into the chip
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_sr <= 5'h15;
         chip_q <= 1'b0;
      end
      else
      begin
         chip_q <= chip_clk;
         if (~chip_clk & chip_q)
         begin
            ext_sr <= {ext_sr[3:0], ext_sr[4] ^ ext_sr[2]};
         end
      end
   end
   assign ext_code_in = ext_sr[4];
endmodule : capg_partner

// file: tb/tb_capg_top.sv
// Purpose: self-checking bench for acquisition control and code generator
// Assumes: zero-wait APB; a short dwell is written before searching
// Notes:   stuck recovery needs a long equal run on ext_code_in, so it is left out
`timescale 1ns/10ps

// ==========================================================================
// Testbench
module tb_capg_top;
   import capg_pkg::*;
   localparam int DW = 32;
   localparam int CODE_LEN = 2047;
   logic pclk, presetn, psel, penable, pwrite, ext_en_in, ext_code_in, comp_in;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] thresh_code, tq, tbi;
   logic pready, pslverr, dump_out, step_out, lock_out, track_en, thresh_biphase;
   logic search_pass, code_true, code_comp, code_early, chip_clk, sync_out, err;
   logic ext_mode, chip_q, dump_q, sync_q, lock_q, early_q;
   logic [10:0] hist;
   logic [3:0] align;
   int errors, compares, seed, cyc, nchip, nslip, nsteps, nsync;
   int last_rise, last_step, dump_rise, sync_rise, sync_steps, steps0;

   capg_top #(.DWELL_TICKS(DWELL_TICKS_DEF)) DUT
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .comp_in(comp_in), .dump_out(dump_out), .step_out(step_out), .lock_out(lock_out),
      .track_en(track_en), .thresh_code(thresh_code), .thresh_biphase(thresh_biphase),
      .search_pass(search_pass), .ext_en_in(ext_en_in), .ext_code_in(ext_code_in),
      .code_true(code_true), .code_comp(code_comp), .code_early(code_early),
      .chip_clk(chip_clk), .sync_out(sync_out)
   );

   capg_partner PARTNER
   (
      .pclk(pclk), .presetn(presetn), .step_out(step_out), .dump_out(dump_out),
      .chip_clk(chip_clk), .align_steps(align), .comp_in(comp_in), .ext_code_in(ext_code_in)
   );

   // ========================================================================
   // Clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         errors++;
         stop_test();
      end
   end

   // ========================================================================
   // Compare and bus tasks
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({31'h0, got}, {31'h0, exp}, what);
   endtask : chk_bit

   // Next chip of the stage 9 and 11 recurrence, from the last eleven chips
   function automatic logic exp_chip(input logic [10:0] h);
      return h[8] ^ h[10];
   endfunction : exp_chip

   task automatic stop_test();
      if (errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test

   // Request held until pready is seen high; data taken at that edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, a, 32'h0);
      chk_word(rd, exp, "read data");
      chk_bit(err, exp_err, "slave error");
   endtask : rd_chk

   // ========================================================================
   // Output monitor, sampled mid-cycle where outputs have settled
   always @(negedge pclk)
   begin
      if (presetn === 1'b1)
      begin
         chk_bit(track_en, lock_out, "track path");
         if (chip_clk === 1'b1 && chip_q === 1'b0)
         begin
            if (last_rise != 0)
               chk_bit(cyc - last_rise == 4 || cyc - last_rise == 3, 1'b1, "chip period");
            if (last_rise != 0 && cyc - last_rise == 3)
               nslip++;
            last_rise = cyc;
         end
         if (chip_clk === 1'b0 && chip_q === 1'b1)
         begin
            chk_bit(code_comp, ~code_true, "complement");
            if (nchip > 0)
               chk_bit(code_true, early_q, "final stage shift");
            if (ext_mode && nchip >= 2)
               chk_bit(code_early, ext_code_in, "external code");
            if (!ext_mode && nchip >= 11)
               chk_bit(code_true, exp_chip(hist), "code recurrence");
            hist = {hist[9:0], code_true};
            early_q = code_early;
            nchip++;
         end
         if (dump_out === 1'b1 && dump_q === 1'b0)
            dump_rise = cyc;
         if (dump_out === 1'b0 && dump_q === 1'b1)
            chk_word(32'(cyc - dump_rise), 32'(DUMP_CYC), "dump width");
         if (step_out === 1'b1)
         begin
            chk_bit(dump_out & ~dump_q, 1'b1, "dump with step");
            chk_bit(lock_out, 1'b0, "step while locked");
            if (last_step != 0)
               chk_word(32'(cyc - last_step), 32'(DW * 4), "dwell spacing");
            last_step = cyc;
            nsteps++;
         end
         if (lock_out === 1'b1 && lock_q === 1'b0)
            chk_bit(dump_out & ~dump_q, 1'b1, "lock at dwell end");
         if (sync_out === 1'b1 && sync_q === 1'b0)
         begin
            if (sync_rise != 0 && sync_steps == nsteps && !ext_mode)
               chk_word(32'(cyc - sync_rise), 32'(CODE_LEN * 4), "sync period");
            sync_rise = cyc;
            sync_steps = nsteps;
            nsync++;
         end
         if (sync_out === 1'b0 && sync_q === 1'b1)
            chk_word(32'(cyc - sync_rise), 32'(SYNC_CYC), "sync width");
      end
      chip_q = chip_clk;
      dump_q = dump_out;
      sync_q = sync_out;
      lock_q = lock_out;
   end

   // ========================================================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, ext_en_in, ext_mode} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      align = 4'hf;
      hist = 11'h0;
      seed = 39142;
      repeat (6) @(posedge pclk);
      chk_bit(code_true, 1'b1, "reset code");
      chk_bit(code_comp, 1'b0, "reset complement");
      presetn <= 1'b1;
      rd_chk(ADDR_CTRL, 32'h0, 1'b0);
      rd_chk(ADDR_DWELL, 32'(DWELL_TICKS_DEF), 1'b0);
      rd_chk(ADDR_THR_QUAD, {24'h0, THR_QUAD_RESET}, 1'b0);
      rd_chk(ADDR_THR_BI, {24'h0, THR_BI_RESET}, 1'b0);
      rd_chk(ADDR_STATUS, 32'h0, 1'b0);
      apb(1'b1, ADDR_POS, 32'h5);
      rd_chk(ADDR_POS, 32'h0, 1'b0);
      rd_chk(12'h7f0, 32'h0, 1'b1);
      // Mode select picks one of two random thresholds
      tq = 8'($random(seed));
      tbi = 8'($random(seed));
      apb(1'b1, ADDR_THR_QUAD, {24'h0, tq});
      apb(1'b1, ADDR_THR_BI, {24'h0, tbi});
      repeat (2) @(posedge pclk);
      chk_word({24'h0, thresh_code}, {24'h0, tq}, "quad threshold");
      apb(1'b1, ADDR_CTRL, 32'h2);
      repeat (2) @(posedge pclk);
      chk_word({24'h0, thresh_code}, {24'h0, tbi}, "biphase threshold");
      chk_bit(thresh_biphase, 1'b1, "mode select");
      apb(1'b1, ADDR_CTRL, 32'h0);
      // Free running code gives whole sync periods
      while (nsync < 3)
         @(posedge pclk);
      // Search with a random number of misses before the hit
      align = 4'(2 + ($random(seed) & 3));
      apb(1'b1, ADDR_DWELL, 32'(DW));
      last_step = 0;
      apb(1'b1, ADDR_CTRL, 32'h1);
      while (lock_out !== 1'b1)
         @(posedge pclk);
      chk_word(32'(nsteps), {28'h0, align}, "steps to lock");
      rd_chk(ADDR_POS, {28'h0, align}, 1'b0);
      rd_chk(ADDR_STATUS, 32'h1, 1'b0);
      chk_bit(search_pass, 1'b0, "quad pass flag");
      // Restart while aligned: relock at the first dwell, no step
      steps0 = nsteps;
      apb(1'b1, ADDR_CTRL, 32'h9);
      repeat (3) @(posedge pclk);
      chk_bit(lock_out, 1'b0, "restart drops lock");
      while (lock_out !== 1'b1)
         @(posedge pclk);
      chk_word(32'(nsteps), 32'(steps0), "no step on hit");
      rd_chk(ADDR_POS, 32'h0, 1'b0);
      // External code, first by the control bit, then by the pin
      apb(1'b1, ADDR_CTRL, 32'h4);
      ext_mode = 1'b1;
      nchip = 0;
      sync_rise = 0;
      rd_chk(ADDR_CTRL, 32'h4, 1'b0);
      repeat (80) @(posedge pclk);
      // Pin raised before the bit drops, so injection never pauses
      ext_en_in <= 1'b1;
      apb(1'b1, ADDR_CTRL, 32'h0);
      repeat (80) @(posedge pclk);
      chk_word(32'(nslip), 32'(nsteps), "slips per step");
      stop_test();
   end
endmodule : tb_capg_top
